// >>> hpl_power_logic.sv
/*
 Hot plug power-state logic: repeats hot plug to the source, decides
 low power or active, detects unplug, repeats adapter detect.
 Assumes pins are asynchronous to sys_clk; tri-state pins are resolved
 outside from the output enables.
*/
`timescale 1ns/100ps
module hpl_power_logic import hpl_pkg::*; #(
	parameter int UNPLUG_TICK_COUNT = UNPLUG_TICKS,
	parameter int TICK_DIV = TICK_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Connector side
	input wire logic hot_plug_in,
	input wire logic adapter_detect_in,
	// Control pins
	input wire logic low_power_select_n,
	input wire logic adapter_detect_invert,
	// Source side
	output logic hot_plug_out,
	output logic hot_plug_out_oe,
	output logic adapter_detect_out,
	output logic adapter_detect_out_oe,
	// Main link and aux output enable
	output logic link_enable
);
	logic [SYNC_STAGES-1:0] hp_sync_reg;
	logic [SYNC_STAGES-1:0] lp_sync_reg;
	logic [SYNC_STAGES-1:0] cad_sync_reg;
	logic [SYNC_STAGES-1:0] inv_sync_reg;
	logic hp_reg;
	logic lp_reg;
	logic cad_reg;
	logic inv_reg;
	hpl_state_t state_reg;
	hpl_state_t state_next;
	logic [19:0] unplug_cnt_reg;
	logic hp_out_reg;
	logic adapter_detect_out_reg;
	logic tick;

	// Three-stage synchronisers; a level counts once stages 2 and 3 agree
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hp_sync_reg <= '0;
			lp_sync_reg <= '0;
			cad_sync_reg <= '0;
			inv_sync_reg <= '0;
		end else begin
			hp_sync_reg <= {hp_sync_reg[1:0], hot_plug_in};
			lp_sync_reg <= {lp_sync_reg[1:0], low_power_select_n};
			cad_sync_reg <= {cad_sync_reg[1:0], adapter_detect_in};
			inv_sync_reg <= {inv_sync_reg[1:0], adapter_detect_invert};
		end
	end

	wire hp_agree = hp_sync_reg[1] == hp_sync_reg[2];
	wire lp_agree = lp_sync_reg[1] == lp_sync_reg[2];
	wire cad_agree = cad_sync_reg[1] == cad_sync_reg[2];
	wire inv_agree = inv_sync_reg[1] == inv_sync_reg[2];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hp_reg <= 1'b0;
			lp_reg <= 1'b0;
			cad_reg <= 1'b0;
			inv_reg <= 1'b0;
		end else begin
			if (hp_agree) hp_reg <= hp_sync_reg[2];
			if (lp_agree) lp_reg <= lp_sync_reg[2];
			if (cad_agree) cad_reg <= cad_sync_reg[2];
			if (inv_agree) inv_reg <= inv_sync_reg[2];
		end
	end

	wire hp_new = hp_agree ? hp_sync_reg[2] : hp_reg;
	wire hp_rise = hp_new && !hp_reg;
	wire hp_low = !hp_reg;
	wire tick_run = hp_low && state_reg == HPL_ACTIVE;

	// Unplug timer on a microsecond time base
	hpl_tick #(
		.DIV(TICK_DIV)
	) u_tick (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.run(tick_run),
		.tick(tick)
	);

	wire unplug = (unplug_cnt_reg == 20'(UNPLUG_TICK_COUNT));

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			unplug_cnt_reg <= 20'h00000;
		end else if (!hp_low || state_reg != HPL_ACTIVE) begin
			unplug_cnt_reg <= 20'h00000;
		end else if (tick && !unplug) begin
			unplug_cnt_reg <= unplug_cnt_reg + 20'h00001;
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			HPL_LOW_POWER: begin
				if (lp_reg && hp_rise) begin
					state_next = HPL_ACTIVE;
				end
			end
			HPL_ACTIVE: begin
				if (!lp_reg) begin
					state_next = HPL_LOW_POWER;
				end else if (unplug) begin
					state_next = HPL_LOW_POWER;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= HPL_LOW_POWER;
		end else begin
			state_reg <= state_next;
		end
	end

	wire active = state_reg == HPL_ACTIVE;

	// Output data registered; low pulses pass with fixed latency
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hp_out_reg <= 1'b0;
			adapter_detect_out_reg <= 1'b0;
		end else begin
			hp_out_reg <= active && hp_reg;
			adapter_detect_out_reg <= cad_reg ^ inv_reg;
		end
	end

	assign hot_plug_out = hp_out_reg;
	assign adapter_detect_out = adapter_detect_out_reg;
	assign hot_plug_out_oe = active;
	assign adapter_detect_out_oe = active;
	assign link_enable = active;

	a_force_low_power: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		!lp_reg |=> !active) else $error("select low did not force low power");
	a_wake_on_rise: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(!active && lp_reg && hp_rise) |=> active) else $error("no wake");
	a_no_wake_forced: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(!active && !lp_reg) |=> !active) else $error("woke while forced");

	a_track_input: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(active && $past(active)) |-> hot_plug_out == $past(hp_reg))
		else $error("hot plug out not tracking");
	a_oe_active: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		hot_plug_out_oe == link_enable && link_enable == active)
		else $error("enables differ from state");
	a_cad_oe_state: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		adapter_detect_out_oe == active)
		else $error("adapter detect enable differs from state");

	a_cad_invert: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		##1 adapter_detect_out == ($past(cad_reg) ^ $past(inv_reg)))
		else $error("adapter detect wrong");
	a_unplug_exit: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(active && unplug) |=> !active) else $error("unplug ignored");
	a_timer_bound: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		unplug_cnt_reg <= 20'(UNPLUG_TICK_COUNT)) else $error("timer overrun");

	a_timer_clear: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		$rose(hp_reg) |=> unplug_cnt_reg == 20'h00000)
		else $error("timer not cleared");
	a_timer_step: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(active && hp_low && tick && !unplug)
		|=> unplug_cnt_reg == $past(unplug_cnt_reg) + 20'h00001)
		else $error("timer did not advance on tick");
	a_timer_idle: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(!active && $past(!active)) |-> unplug_cnt_reg == 20'h00000)
		else $error("timer running in low power");

	a_low_pw_quiet: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		!active |=> !hot_plug_out) else $error("output high in low power");
	a_pulse_stays: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(active && lp_reg && !unplug) |=> active)
		else $error("short low pulse left active state");
	a_no_wake_low: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(!active && !hp_rise) |=> !active) else $error("woke without rise");
	a_rise_taken: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		hp_rise |=> hp_reg) else $error("rise not taken");
	a_wake_again: assert property (
		@(posedge sys_clk) disable iff (!rstn)
		(!active && $past(active) && lp_reg && hp_rise) |=> active)
		else $error("no wake after unplug");
endmodule

// >>> hpl_pkg.sv
/*
 Package for the hot plug power-state logic: timing figures and the
 cycle counts derived from them at the system clock rate.
 Assumes a 250 MHz system clock.
*/
package hpl_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	// Unplug switch time window, in ms
	localparam int UNPLUG_MIN_MS = 200;
	localparam int UNPLUG_MAX_MS = 400;
	// Unplug detection point chosen mid-window, in ms
	localparam int UNPLUG_SET_MS = 300;
	localparam int CYC_PER_MS = 1000000000 / CLK_PERIOD_PS;
	localparam int UNPLUG_CYCLES = UNPLUG_SET_MS * CYC_PER_MS;
	// Shortest low pulse that must be repeated, in ns
	localparam int MIN_PULSE_NS = 100;
	localparam int MIN_PULSE_CYCLES =
		(MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Time base tick: one pulse per microsecond
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = TICK_NS * 1000 / CLK_PERIOD_PS;
	localparam int UNPLUG_TICKS = UNPLUG_SET_MS * 1000;
	localparam int SYNC_STAGES = 3;
	typedef enum logic [0:0] {HPL_LOW_POWER, HPL_ACTIVE} hpl_state_t;
endpackage

// >>> hpl_tick.sv
/*
 Time base divider: one-cycle enable pulse every DIV cycles.
 Assumes a single free-running clock.
*/
`timescale 1ns/100ps
module hpl_tick import hpl_pkg::*; #(
	parameter int DIV = TICK_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Enable
	input wire logic run,
	output logic tick
);
	logic [15:0] cnt_reg;
	wire wrap = (cnt_reg == 16'(DIV - 1));
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 16'h0000;
		end else if (!run || wrap) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end
	assign tick = run && wrap;
endmodule

// >>> hpl_sink.sv
/*
 Connector side model: drives the hot plug and adapter detect pins.
 Assumes callers invoke its tasks at a falling edge of sys_clk.
*/
`timescale 1ns/100ps
module hpl_sink (
	// Clock
	input wire logic sys_clk,
	// Connector pins
	output logic hot_plug_in,
	output logic adapter_detect_in
);
	initial begin
		hot_plug_in = 1'b0;
		adapter_detect_in = 1'b0;
	end
	// Sets hot plug now, then holds it for n cycles
	task automatic hold(input logic lvl, input int n);
		hot_plug_in = lvl;
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic cable(input logic lvl);
		adapter_detect_in = lvl;
	endtask
endmodule

// >>> testbench.sv
/*
 Self-checking bench for the hot plug power-state logic.
 Assumes shortened unplug timing: 40 ticks of 2 cycles.
*/
`timescale 1ns/100ps
module testbench;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic low_power_select_n = 1'b1;
	logic adapter_detect_invert = 1'b0;
	logic hot_plug_in, adapter_detect_in, hot_plug_out, hot_plug_out_oe;
	logic adapter_detect_out, adapter_detect_out_oe, link_enable;
	int error_cnt = 0;
	int checks = 0;
	always #2 sys_clk = ~sys_clk;
	hpl_sink u_sink (.sys_clk(sys_clk), .hot_plug_in(hot_plug_in),
		.adapter_detect_in(adapter_detect_in));
	hpl_power_logic #(.UNPLUG_TICK_COUNT(40), .TICK_DIV(2)) u_dut (
		.sys_clk(sys_clk), .rstn(rstn), .hot_plug_in(hot_plug_in),
		.adapter_detect_in(adapter_detect_in),
		.low_power_select_n(low_power_select_n),
		.adapter_detect_invert(adapter_detect_invert),
		.hot_plug_out(hot_plug_out), .hot_plug_out_oe(hot_plug_out_oe),
		.adapter_detect_out(adapter_detect_out),
		.adapter_detect_out_oe(adapter_detect_out_oe),
		.link_enable(link_enable));
	task automatic chk(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic chk_n(input string name, input int exp, input int got);
		checks++;
		if (got != exp) begin
			error_cnt++;
			$display("mismatch %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	// All enables follow the power state together
	task automatic st(input logic on);
		chk("link_enable", on, link_enable);
		chk("hot_plug_out_oe", on, hot_plug_out_oe);
		chk("adapter_detect_out_oe", on, adapter_detect_out_oe);
	endtask
	task automatic t_forced;
		low_power_select_n = 1'b0;
		u_sink.hold(1'b1, 20);
		st(1'b0);
		chk("hot_plug_out", 1'b0, hot_plug_out);
		$display("test forced done");
	endtask
	task automatic t_wake;
		low_power_select_n = 1'b1;
		u_sink.hold(1'b0, 10);
		st(1'b0);
		u_sink.hold(1'b1, 10);
		st(1'b1);
		chk("hot_plug_out", 1'b1, hot_plug_out);
		$display("test wake done");
	endtask
	// First 60-cycle pulse only survives if the timer cleared on rise
	task automatic t_pulse;
		int wid[3] = '{25, 60, 60};
		int w;
		for (int p = 0; p < 3; p++) begin
			w = 0;
			fork
				begin
					u_sink.hold(1'b0, wid[p]);
					u_sink.hold(1'b1, 1);
				end
				begin
					for (int i = 0; i < 12 && hot_plug_out !== 1'b0; i++)
						@(negedge sys_clk);
					while (hot_plug_out === 1'b0 && w < 100) begin
						@(negedge sys_clk);
						w++;
					end
				end
			join
			u_sink.hold(1'b1, 10);
			chk_n("pulse width", wid[p], w);
			st(1'b1);
		end
		$display("test pulse done");
	endtask
	task automatic t_adapter;
		for (int k = 0; k < 4; k++) begin
			adapter_detect_invert = k[1];
			u_sink.cable(k[0]);
			repeat (8) @(negedge sys_clk);
			chk("adapter_detect_out", k[0] ^ k[1], adapter_detect_out);
		end
		$display("test adapter done");
	endtask
	task automatic t_unplug;
		u_sink.hold(1'b0, 120);
		st(1'b0);
		chk("hot_plug_out", 1'b0, hot_plug_out);
		u_sink.hold(1'b1, 10);
		st(1'b1);
		$display("test unplug done");
	endtask
	task automatic t_drop;
		low_power_select_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		st(1'b0);
		low_power_select_n = 1'b1;
		u_sink.hold(1'b0, 10);
		u_sink.hold(1'b1, 10);
		st(1'b1);
		$display("test drop done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_forced();
		t_wake();
		t_pulse();
		t_adapter();
		t_unplug();
		t_drop();
		complete_run();
	end
	// Tests take about 430 cycles
	initial begin
		#20000;
		error_cnt++;
		complete_run();
	end
endmodule
